// ==== hw/pdkr_pkg.sv ====
// Package: offsets, reset values and decode helpers for the port
// debounce and key-entry reset block.
// Assumes a 32-bit Wishbone bus with word-aligned registers.
package pdkr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_MASK  = 16'h5205;
    localparam logic [15:0] IDX_EDGE  = 16'h5206;
    localparam logic [15:0] IDX_FLAG  = 16'h5207;
    localparam logic [15:0] IDX_CHAT  = 16'h5208;
    localparam logic [15:0] IDX_KRST  = 16'h5209;
    localparam logic [15:0] IDX_LEVEL = 16'h520F;

    // Field positions
    localparam int          LO_SEL_LSB = 0;
    localparam int          HI_SEL_LSB = 4;
    localparam int          SEL_W      = 3;

    // Writable bits; others read zero
    localparam logic [7:0]  CHAT_WMASK = 8'h77;
    localparam logic [7:0]  KRST_WMASK = 8'h03;

    // Reset values
    localparam logic [7:0]  CHAT_RST   = 8'h00;
    localparam logic [1:0]  KRST_RST   = 2'h0;
    localparam logic [7:0]  MASK_RST   = 8'h00;
    localparam logic [7:0]  EDGE_RST   = 8'h00;
    localparam logic [7:0]  FLAG_RST   = 8'h00;

    // Filter timing in peripheral clock cycles
    localparam logic [2:0]  FILT_OFF     = 3'h0;
    localparam int          FILT_BASE_CYC = 256;

    // Byte address of a register index
    function automatic logic [31:0] pdkr_addr(input logic [15:0] idx);
        return {14'h0000, idx, 2'h0};
    endfunction

    // Pins taking part in key-entry reset
    function automatic logic [3:0] pdkr_grp_mask(input logic [1:0] sel);
        unique case (sel)
            2'h3: return 4'hF;
            2'h2: return 4'h7;
            2'h1: return 4'h3;
            2'h0: return 4'h0;
        endcase
    endfunction

    // Hold time: twice the check time, base << sel
    function automatic logic [31:0] pdkr_hold_cyc(input logic [2:0] sel,
                                                  input int base);
        return 32'(base) << sel;
    endfunction

endpackage

// ==== hw/pdkr_sync.sv ====
// Two-flop synchroniser for the port pins.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/100ps
module pdkr_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // pdkr_sync

// ==== hw/pdkr_nib_filter.sv ====
// Chattering filter for one nibble of port pins.
// Assumes din_i is already synchronised to clk_i.
`timescale 1ns/100ps
module pdkr_nib_filter #(
    parameter int W     = 4,
    parameter int CNT_W = 16,
    parameter int BASE  = 256
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [2:0]   sel_i,
    input  wire logic [W-1:0] din_i,
    output logic      [W-1:0] dout_o
);
    import pdkr_pkg::*;

    logic [W-1:0]     prev_q, prev_d;
    logic [W-1:0]     dout_q, dout_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] last;

    assign last = CNT_W'(pdkr_hold_cyc(sel_i, BASE) - 32'h1);

    always_comb begin
        prev_d = din_i;
        cnt_d  = cnt_q;
        dout_d = dout_q;
        if (sel_i == FILT_OFF) begin // R02
            cnt_d  = '0;
            dout_d = din_i;
        end else if (din_i != prev_q) begin // R15
            cnt_d = '0;
        end else if (cnt_q >= last) begin // R03 R04 R15
            dout_d = prev_q;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= '1;
            dout_q <= '1;
            cnt_q  <= '0;
        end else begin
            prev_q <= prev_d;
            dout_q <= dout_d;
            cnt_q  <= cnt_d;
        end
    end

    assign dout_o = dout_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_bypass_follow: assert property ( // R02
        (sel_i == FILT_OFF) |=> (dout_o == $past(din_i)))
        else $error("Bypassed filter did not follow input");
    a_glitch_hold: assert property ( // R03
        (sel_i != FILT_OFF && $stable(sel_i) && din_i != prev_q)
        |=> $stable(dout_o))
        else $error("Filtered level moved on an unsettled input");
    a_change_late: assert property ( // R04
        (sel_i != FILT_OFF && $stable(sel_i) && $changed(dout_o))
        |-> ($past(cnt_q) >= $past(last)))
        else $error("Filtered level changed before hold time");
    a_cnt_restart: assert property ( // R15
        (sel_i != FILT_OFF && din_i != prev_q) |=> (cnt_q == '0))
        else $error("Counter did not restart on input change");
endmodule // pdkr_nib_filter

// ==== hw/pdkr_top.sv ====
// Top of the port debounce and key-entry reset block: Wishbone
// slave, pin synchroniser, two nibble filters, edge flags, key reset.
// Assumes classic Wishbone master on clk_i; pins are asynchronous.
//
// Notes on behaviour
// R01 - Low nibble uses bits 2:0, high 6:4
// R02 - Zero bypasses; else 256 to 16384 cycles
// R03 - Pulses up to check time are suppressed
// R04 - Edge passes after twice check time
// R05 - Software disables filter before sleep
// R06 - Software masks interrupts before filter writes
// R07 - Software waits twice check time after change
// R08 - Select picks pins 0-1, 0-2, 0-3 or none
// R09 - All selected pins low asserts reset
// R10 - Reset clears key-reset select to disabled
// R11 - Application never drives selected pins low together
// R12 - Software writes zero when unused
// R13 - Flag set on chosen edge of filtered pin
// R14 - Fields reset zero; reserved bits read zero
// R15 - Per-nibble counter restarts on change
`timescale 1ns/100ps
module pdkr_top #(
    parameter int FILT_BASE = pdkr_pkg::FILT_BASE_CYC,
    parameter int CNT_W     = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    output logic             err_o,
    input  wire logic [7:0]  pins_i,
    output logic             irq_o,
    output logic             key_rst_o
);
    import pdkr_pkg::*;

    logic [7:0]  pins_s;
    logic [7:0]  filt;
    logic [2:0]  lo_sel, hi_sel;

    logic [7:0]  chat_q, chat_d;
    logic [1:0]  krst_q, krst_d;
    logic [7:0]  mask_q, mask_d;
    logic [7:0]  edge_q, edge_d;
    logic [7:0]  flag_q, flag_d;
    logic [7:0]  filt_q;
    logic        key_rst_q, key_rst_d;

    logic        ack_q, ack_d;
    logic        err_q, err_d;
    logic [31:0] dat_q, dat_d;

    logic        req, wr, mapped;
    logic        hit_mask, hit_edge, hit_flag;
    logic        hit_chat, hit_krst, hit_level;
    logic [7:0]  rise, fall, ev, w1c;
    logic [7:0]  rdat;

    // Pin synchroniser
    pdkr_sync #(
        .W       (8)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pins_i),
        .sync_o  (pins_s)
    );

    assign lo_sel = chat_q[LO_SEL_LSB +: SEL_W]; // R01
    assign hi_sel = chat_q[HI_SEL_LSB +: SEL_W]; // R01

    // One filter per nibble
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_nib
            pdkr_nib_filter #(
                .W      (4),
                .CNT_W  (CNT_W),
                .BASE   (FILT_BASE)
            ) u_filt (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .sel_i  ((g == 0) ? lo_sel : hi_sel),
                .din_i  (pins_s[g*4 +: 4]),
                .dout_o (filt[g*4 +: 4])
            );
        end
    endgenerate

    // Bus decode
    assign req       = cyc_i & stb_i;
    assign hit_mask  = (adr_i == pdkr_addr(IDX_MASK));
    assign hit_edge  = (adr_i == pdkr_addr(IDX_EDGE));
    assign hit_flag  = (adr_i == pdkr_addr(IDX_FLAG));
    assign hit_chat  = (adr_i == pdkr_addr(IDX_CHAT));
    assign hit_krst  = (adr_i == pdkr_addr(IDX_KRST));
    assign hit_level = (adr_i == pdkr_addr(IDX_LEVEL));
    assign mapped    = hit_mask | hit_edge | hit_flag
                     | hit_chat | hit_krst | hit_level;
    // Write lands on the edge where the master sees ack
    assign wr        = req & we_i & ack_q & sel_i[0];

    always_comb begin
        unique case (1'b1)
            hit_mask:  rdat = mask_q;
            hit_edge:  rdat = edge_q;
            hit_flag:  rdat = flag_q;
            hit_chat:  rdat = chat_q & CHAT_WMASK; // R14
            hit_krst:  rdat = {6'h00, krst_q}; // R14
            hit_level: rdat = filt_q;
            default:   rdat = 8'h00;
        endcase
    end

    always_comb begin
        ack_d = req & ~ack_q & ~err_q & mapped;
        err_d = req & ~ack_q & ~err_q & ~mapped;
        dat_d = dat_q;
        if (ack_d | err_d) begin
            dat_d = {24'h000000, (ack_d ? rdat : 8'h00)};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            err_q <= err_d;
            dat_q <= dat_d;
        end
    end

    // Edge detection on filtered levels
    assign rise = filt & ~filt_q;
    assign fall = ~filt & filt_q;
    assign ev   = (edge_q & fall) | (~edge_q & rise); // R13
    assign w1c  = (wr & hit_flag) ? dat_i[7:0] : 8'h00;

    // Control and status registers
    always_comb begin
        chat_d = chat_q;
        krst_d = krst_q;
        mask_d = mask_q;
        edge_d = edge_q;
        if (wr & hit_chat) begin
            chat_d = dat_i[7:0] & CHAT_WMASK; // R01 R14
        end
        if (wr & hit_krst) begin
            krst_d = dat_i[1:0]; // R08
        end
        if (wr & hit_mask) begin
            mask_d = dat_i[7:0];
        end
        if (wr & hit_edge) begin
            edge_d = dat_i[7:0];
        end
        flag_d = (flag_q & ~w1c) | ev; // R13
    end

    // Key-entry reset request
    always_comb begin
        key_rst_d = (krst_q != 2'h0) // R09
                  && ((pins_s[3:0] & pdkr_grp_mask(krst_q)) == 4'h0); // R08
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chat_q    <= CHAT_RST; // R14
            krst_q    <= KRST_RST; // R10
            mask_q    <= MASK_RST;
            edge_q    <= EDGE_RST;
            flag_q    <= FLAG_RST;
            filt_q    <= 8'hFF;
            key_rst_q <= 1'b0;
        end else begin
            chat_q    <= chat_d;
            krst_q    <= krst_d;
            mask_q    <= mask_d;
            edge_q    <= edge_d;
            flag_q    <= flag_d;
            filt_q    <= filt;
            key_rst_q <= key_rst_d;
        end
    end

    assign ack_o     = ack_q;
    assign err_o     = err_q;
    assign dat_o     = dat_q;
    assign irq_o     = |(flag_q & mask_q);
    assign key_rst_o = key_rst_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wr_chat;
        wr && hit_chat;
    endsequence

    sequence s_rd_chat;
        ack_o && !we_i && hit_chat;
    endsequence

    sequence s_rd_krst;
        ack_o && !we_i && hit_krst;
    endsequence

    sequence s_rd_level;
        ack_o && !we_i && hit_level;
    endsequence

    a_low_nib_cfg: assert property ( // R01
        s_wr_chat |=> (lo_sel == $past(dat_i[2:0])))
        else $error("Low nibble select not taken from bits 2:0");
    a_high_nib_cfg: assert property ( // R01
        s_wr_chat |=> (hi_sel == $past(dat_i[6:4])))
        else $error("High nibble select not taken from bits 6:4");
    a_grp_mask: assert property ( // R08
        (krst_q == 2'h1 && pins_s[1:0] == 2'h0) |=> key_rst_o)
        else $error("Two-pin group low did not raise key reset");
    a_key_rst_cause: assert property ( // R09
        key_rst_o |-> ($past(krst_q) != 2'h0) &&
            (($past(pins_s[3:0]) & pdkr_grp_mask($past(krst_q)))
             == 4'h0))
        else $error("Key reset without all selected pins low");
    a_krst_cleared: assert property ( // R10
        $fell(rst_i) |-> (krst_q == 2'h0) && !key_rst_o)
        else $error("Key reset select not cleared by reset");
    a_rsvd_zero: assert property ( // R14
        s_rd_chat |-> (dat_o[7] == 1'b0) && (dat_o[3] == 1'b0)
            && (dat_o[31:8] == 24'h000000))
        else $error("Reserved bits of filter control read nonzero");
    a_flag_on_edge: assert property ( // R13
        (ev != 8'h00) |=> ((flag_q & $past(ev)) == $past(ev)))
        else $error("Edge did not set its flag");
    a_ack_one_cycle: assert property (
        ack_o |=> !ack_o)
        else $error("Ack held for more than one cycle");

    // Bus handshake
    a_err_one_cycle: assert property (
        err_o |=> !err_o)
        else $error("Error held for more than one cycle");
    a_mapped_ack: assert property (
        (req && !ack_o && !err_o && mapped) |=> ack_o)
        else $error("Mapped request not acknowledged");
    a_unmapped_err: assert property (
        (req && !ack_o && !err_o && !mapped) |=> err_o)
        else $error("Unmapped request not refused");
    a_err_no_data: assert property (
        err_o |-> (dat_o == 32'h00000000))
        else $error("Refused request returned data");
    a_err_no_write: assert property (
        err_o |=> $stable(chat_q) && $stable(krst_q) && $stable(mask_q))
        else $error("Refused request changed a register");
    a_sel_ignored: assert property (
        (req && we_i && ack_o && !sel_i[0]) |=> $stable(chat_q)
            && $stable(krst_q))
        else $error("Write without low byte enable landed");

    // Reserved bits and level readback
    a_chat_rsvd_wr: assert property ( // R14
        s_wr_chat |=> (chat_q[7] == 1'b0) && (chat_q[3] == 1'b0))
        else $error("Reserved filter control bit was stored");
    a_krst_rsvd: assert property ( // R14
        s_rd_krst |-> (dat_o[31:2] == 30'h00000000))
        else $error("Reserved bits of key reset select read nonzero");
    a_level_read: assert property (
        s_rd_level |-> (dat_o[7:0] == $past(filt_q)))
        else $error("Filtered level read back wrong");

    // Key-entry reset groups
    a_grp_three: assert property ( // R08
        (krst_q == 2'h2 && pins_s[2:0] == 3'h0) |=> key_rst_o)
        else $error("Three-pin group low did not raise key reset");
    a_grp_four: assert property ( // R08
        (krst_q == 2'h3 && pins_s[3:0] == 4'h0) |=> key_rst_o)
        else $error("Four-pin group low did not raise key reset");
    a_key_rst_off: assert property ( // R08
        (krst_q == 2'h0) |=> !key_rst_o)
        else $error("Key reset raised while disabled");
    a_key_rst_fall: assert property ( // R09
        ((pins_s[3:0] & pdkr_grp_mask(krst_q)) != 4'h0) |=> !key_rst_o)
        else $error("Key reset held with a selected pin high");

    // Flag set and clear
    a_flag_sticky: assert property ( // R13
        (w1c == 8'h00) |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
        else $error("Flag dropped without a clear");
    a_flag_clear: assert property ( // R13
        (wr && hit_flag)
            |=> ((flag_q & $past(w1c) & ~$past(ev)) == 8'h00))
        else $error("Flag not cleared by writing one");
endmodule // pdkr_top

// ==== verification/pdkr_keys.sv ====
// Key switch model standing on the port pins.
// Assumes pull-ups on every pin: an open key reads high.
`timescale 1ns/100ps
module pdkr_keys (
    input  wire logic       clk_i,
    output logic      [7:0] pins_o
);
    initial pins_o = 8'hFF;

    // Closed keys pull their pins low
    task automatic press(input logic [7:0] m);
        @(posedge clk_i);
        pins_o <= ~m;
    endtask
endmodule // pdkr_keys

// ==== verification/tb.sv ====
// Testbench for the port debounce and key-entry reset block.
// Assumes the key switch model drives the pins, one clock domain.
`timescale 1ns/100ps
module tb;
    import pdkr_pkg::*;
    localparam int BASE = 4;
    typedef struct {logic [15:0] a; logic w; logic [7:0] d;
        logic [3:0] s; logic [7:0] x; logic er;} pdkr_row_type;
    logic         clk_i;
    logic         rst_i;
    logic  [31:0] adr_i;
    logic  [31:0] dat_i;
    logic  [3:0]  sel_i;
    logic         we_i;
    logic         cyc_i;
    logic         stb_i;
    logic  [31:0] dat_o;
    logic         ack_o, err_o, irq_o, key_rst_o, e;
    logic  [7:0]  pins_i, q;
    int           h;
    int           errors = 0;
    int           checks = 0;
    pdkr_row_type rows[11] = '{
        '{IDX_CHAT, 1'h0, 8'h00, 4'hF, 8'h00, 1'h0},
        '{IDX_KRST, 1'h0, 8'h00, 4'hF, 8'h00, 1'h0},
        '{IDX_CHAT, 1'h1, 8'hFF, 4'hF, 8'h00, 1'h0},
        '{IDX_CHAT, 1'h0, 8'h00, 4'hF, 8'h77, 1'h0},
        '{IDX_KRST, 1'h1, 8'hFF, 4'hF, 8'h00, 1'h0},
        '{IDX_KRST, 1'h0, 8'h00, 4'hF, 8'h03, 1'h0},
        '{IDX_CHAT, 1'h1, 8'h12, 4'h0, 8'h00, 1'h0},
        '{IDX_CHAT, 1'h0, 8'h00, 4'hF, 8'h77, 1'h0},
        '{16'h5200, 1'h0, 8'h00, 4'hF, 8'h00, 1'h1},
        '{IDX_KRST, 1'h1, 8'h00, 4'hF, 8'h00, 1'h0},
        '{IDX_CHAT, 1'h1, 8'h00, 4'hF, 8'h00, 1'h0}};

    pdkr_top #(
        .FILT_BASE (BASE)
    ) i_pdkr_top (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .adr_i     (adr_i),
        .dat_i     (dat_i),
        .dat_o     (dat_o),
        .sel_i     (sel_i),
        .we_i      (we_i),
        .cyc_i     (cyc_i),
        .stb_i     (stb_i),
        .ack_o     (ack_o),
        .err_o     (err_o),
        .pins_i    (pins_i),
        .irq_o     (irq_o),
        .key_rst_o (key_rst_o)
    );
    pdkr_keys i_pdkr_keys (
        .clk_i     (clk_i),
        .pins_o    (pins_i)
    );

    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic complete_run();
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk8(string n, logic [7:0] x, logic [7:0] g);
        checks++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic chk1(string n, logic x, logic g);
        checks++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", n, x, g);
        end
    endtask

    task automatic wb(logic [15:0] a, logic w, logic [7:0] d,
                      logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i  <= w;
        sel_i <= s;
        adr_i <= {14'h0, a, 2'h0};
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'h1 && err_o !== 1'h1);
        q = dat_o[7:0];
        e = err_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i  <= 1'h0;
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        wb(a, 1'h1, d, 4'hF);
    endtask

    task automatic rd(string n, logic [15:0] a, logic [7:0] x);
        wb(a, 1'h0, 8'h00, 4'hF);
        chk8(n, x, q);
    endtask

    initial begin
        rst_i <= 1'h1;
        adr_i <= 32'h0;
        dat_i <= 32'h0;
        sel_i <= 4'h0;
        we_i  <= 1'h0;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        foreach (rows[i]) begin
            wb(rows[i].a, rows[i].w, rows[i].d, rows[i].s);
            chk1("bus err", rows[i].er, e);
            if (!rows[i].w) chk8("reg", rows[i].x, q);
        end
        // Bypass: falling edges on pins 0, 4, 7
        wr(IDX_EDGE, 8'h91);
        wr(IDX_MASK, 8'h10);
        i_pdkr_keys.press(8'h10);
        repeat (6) @(posedge clk_i);
        chk1("irq", 1'h1, irq_o);
        wr(IDX_FLAG, 8'h10);
        @(posedge clk_i);
        chk1("irq clear", 1'h0, irq_o);
        i_pdkr_keys.press(8'h00);
        repeat (6) @(posedge clk_i);
        rd("rise ignored", IDX_FLAG, 8'h00);
        wr(IDX_MASK, 8'h00);
        // Every check time on the high nibble
        for (int s = 1; s < 8; s++) begin
            h = BASE << s;
            wr(IDX_CHAT, 8'(s << 4));
            repeat (2 * h) @(posedge clk_i);
            wr(IDX_FLAG, 8'hFF);
            i_pdkr_keys.press(8'h80);
            repeat (h - 4) @(posedge clk_i);
            rd("early", IDX_FLAG, 8'h00);
            repeat (10) @(posedge clk_i);
            rd("held", IDX_FLAG, 8'h80);
            i_pdkr_keys.press(8'h00);
        end
        // Glitch of one check time: high nibble drops it
        wr(IDX_CHAT, 8'h30);
        repeat (80) @(posedge clk_i);
        wr(IDX_FLAG, 8'hFF);
        i_pdkr_keys.press(8'h11);
        repeat (15) @(posedge clk_i);
        i_pdkr_keys.press(8'h00);
        repeat (60) @(posedge clk_i);
        rd("glitch", IDX_FLAG, 8'h01);
        wr(IDX_CHAT, 8'h00);
        // Key-entry reset groups
        for (int g = 1; g < 4; g++) begin
            wr(IDX_KRST, 8'(g));
            i_pdkr_keys.press(8'((8'h2 << g) - 2));
            repeat (6) @(posedge clk_i);
            chk1("partial", 1'h0, key_rst_o);
            i_pdkr_keys.press(8'((8'h2 << g) - 1));
            repeat (6) @(posedge clk_i);
            chk1("group", 1'h1, key_rst_o);
            i_pdkr_keys.press(8'h00);
        end
        wr(IDX_KRST, 8'h00);
        rd("rising", IDX_FLAG, 8'h0F);
        i_pdkr_keys.press(8'h0F);
        repeat (6) @(posedge clk_i);
        chk1("disabled", 1'h0, key_rst_o);
        i_pdkr_keys.press(8'h00);
        wr(IDX_KRST, 8'h03);
        wr(IDX_CHAT, 8'h77);
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        rd("krst", IDX_KRST, 8'h00);
        rd("chat", IDX_CHAT, 8'h00);
        i_pdkr_keys.press(8'h0F);
        repeat (6) @(posedge clk_i);
        chk1("after reset", 1'h0, key_rst_o);
        rd("level", IDX_LEVEL, 8'hF0);
        complete_run();
    end

    initial begin
        repeat (40000) @(posedge clk_i);
        errors++;
        complete_run();
    end
endmodule // tb
